// [logic/hjd_deb_if.sv]
/*
  Bundle between the top and one debounce filter.
  Assumes one clock domain; all members are sys_clk synchronous.
*/
`timescale 1ns/1ns
interface hjd_deb_if;
  logic tick;
  logic enable;
  logic raw;
  logic [9:0] riseCount;
  logic [9:0] fallCount;
  logic state;
  modport ctrl (output tick, output enable, output raw, output riseCount,
    output fallCount, input state);
  modport filt (input tick, input enable, input raw, input riseCount,
    input fallCount, output state);
endinterface

// [logic/hjd_debounce.sv]
/*
  Consecutive-sample debounce filter with separate counts for each direction.
  Assumes raw is already synchronised and tick is a one-cycle pulse.
*/
`timescale 1ns/1ns
module hjd_debounce
  import hjd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  hjd_deb_if.filt deb
);
  logic [CNT_W-1:0] agreeCount;
  logic [CNT_W-1:0] target;
  logic [CNT_W-1:0] next_agreeCount;

  assign target = deb.state ? deb.fallCount : deb.riseCount;
  assign next_agreeCount = CNT_W'(agreeCount + 1'b1);

  always_ff @(posedge sys_clk) begin
    if (reset || !deb.enable) begin
      agreeCount <= '0;
      deb.state <= 1'b0;
    end else if (deb.tick) begin
      if (deb.raw == deb.state) begin
        agreeCount <= '0;
      end else if (next_agreeCount >= target) begin
        // a count of zero or one accepts the first differing sample
        agreeCount <= '0;
        deb.state <= deb.raw;
      end else begin
        agreeCount <= next_agreeCount;
      end
    end
  end
endmodule

// [logic/hjd_pkg.sv]
/*
  Constants for the headset jack detection configuration block: register
  offsets, field positions, reset values, threshold figures and timing.
  Assumes a 20 MHz system clock.
*/
package hjd_pkg;
  localparam logic [7:0] ADDR_CFG_ONE = 8'h1a;
  localparam logic [7:0] ADDR_DEB_CFG = 8'h1b;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] RESET_CFG_ONE = 8'h00;
  localparam logic [7:0] RESET_DEB_CFG = 8'h00;

  // first configuration register
  localparam int POS_HOOK_THRESHOLD = 6;
  localparam int POS_HOOKED_MIN_LO = 4;
  localparam int POS_COUPLING = 3;
  localparam int POS_DOUBLE_CURRENT = 2;
  localparam int POS_DETECT_ENABLE = 1;
  localparam logic [7:0] CFG_ONE_WRITE_MASK = 8'hfe;
  // debounce register
  localparam int POS_HP_DEBOUNCE = 6;
  localparam int POS_INSERT_LO = 3;
  localparam int POS_REMOVAL = 2;
  localparam int POS_HOOK_LO = 0;
  localparam logic [7:0] DEB_CFG_WRITE_MASK = 8'h7f;
  // status register
  localparam int POS_JACK_FLAG_LO = 6;

  localparam logic [1:0] JACK_NONE = 2'h0;
  localparam logic [1:0] JACK_NO_MIC = 2'h1;
  localparam logic [1:0] JACK_WITH_MIC = 2'h3;

  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_NONE = 10'h000;
  localparam logic [CNT_W-1:0] CNT_HP = 10'h003;
  localparam logic [CNT_W-1:0] CNT_REMOVAL_SLOW = 10'h005;
  localparam logic [CNT_W-1:0] CNT_REMOVAL_FAST = 10'h003;
  localparam logic [CNT_W-1:0] CNT_HOOK_TWO = 10'h002;
  localparam logic [CNT_W-1:0] CNT_HOOK_THREE = 10'h003;
  localparam logic [CNT_W-1:0] INSERT_BASE_MS = 10'h010;
  localparam logic [2:0] INSERT_CODE_MAX = 3'h5;

  localparam int OHM_W = 12;
  localparam logic [OHM_W-1:0] OHM_MIC_LOW = 12'h320;
  localparam logic [OHM_W-1:0] OHM_HOOK_LOW_AC = 12'h140;
  localparam logic [OHM_W-1:0] OHM_HOOK_LOW_DC = 12'h096;
  localparam logic [OHM_W-1:0] OHM_HOOK_HIGH = 12'h2a8;
  localparam logic [OHM_W-1:0] OHM_MIC_HIGH_AC = 12'h546;
  localparam logic [OHM_W-1:0] OHM_MIC_HIGH_DC = 12'h6d6;
  localparam logic [OHM_W-1:0] OHM_HOOKED_150 = 12'h096;
  localparam logic [OHM_W-1:0] OHM_HOOKED_100 = 12'h064;
  localparam logic [OHM_W-1:0] OHM_HOOKED_50 = 12'h032;

  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int DET_BASE_PERIOD_US = 1000;
  localparam int DET_BASE_CYCLES = CLK_FREQ_HZ / 1_000_000 * DET_BASE_PERIOD_US;
  localparam logic [1:0] PERIOD_CODE_MAX = 2'h2;
endpackage

// [logic/hjd_top.sv]
/*
  Headset jack detection configuration and event debounce: two 8-bit
  configuration registers, a read-only status word, a detection sample clock,
  and debounce of insertion, removal, headphone and hook results.
  Assumes comparator results arrive asynchronously and that the control
  interface presents single-cycle read and write strobes on sys_clk.
*/
`timescale 1ns/1ns
module hjd_top
  import hjd_pkg::*;
#(
  parameter int DET_TICK_CYCLES = DET_BASE_CYCLES
)(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWdata,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic [1:0] detectionClockPeriod,
  input wire logic externalResistorType,
  input wire logic jackSense,
  input wire logic micSense,
  input wire logic hookSense,
  output logic headsetDetectEnable,
  output logic couplingDc,
  output logic doubleSenseCurrent,
  output logic [11:0] hookMaxOhm,
  output logic [11:0] micMinOhm,
  output logic [11:0] hookedMinOhm,
  output logic hookedMinValid,
  output logic detectTick,
  output logic [1:0] jackTypeFlag,
  output logic hookPressed
);
  if (DET_TICK_CYCLES < 2) begin : g_check
    $error("DET_TICK_CYCLES must be at least 2");
  end

  //////////////////////////////////////////////////////////////////////////
  logic [7:0] cfgOne;
  logic [7:0] debCfg;
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic [2:0] syncC;
  logic [2:0] senseStable;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfgOne <= RESET_CFG_ONE;
      debCfg <= RESET_DEB_CFG;
    end else if (regWrite) begin
      // reserved read-only bits are masked; writable reserved bits are stored
      if (regAddr == ADDR_CFG_ONE) begin
        cfgOne <= regWdata & CFG_ONE_WRITE_MASK;
      end
      if (regAddr == ADDR_DEB_CFG) begin
        debCfg <= regWdata & DEB_CFG_WRITE_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        ADDR_CFG_ONE: regRdata <= cfgOne;
        ADDR_DEB_CFG: regRdata <= debCfg;
        ADDR_STATUS: regRdata <= {jackTypeFlag, 6'h00};
        default: regRdata <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // three-stage synchroniser; a level counts once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      syncA <= 3'h0;
      syncB <= 3'h0;
      syncC <= 3'h0;
      senseStable <= 3'h0;
    end else begin
      syncA <= {hookSense, micSense, jackSense};
      syncB <= syncA;
      syncC <= syncB;
      for (int i = 0; i < 3; i++) begin
        if (syncB[i] == syncC[i]) begin
          senseStable[i] <= syncC[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  logic [$clog2(DET_TICK_CYCLES)-1:0] baseCount;
  logic [1:0] periodCount;
  logic [1:0] periodSel;
  logic [1:0] periodLast;
  logic next_detectEnable;

  assign headsetDetectEnable = cfgOne[POS_DETECT_ENABLE];
  // a write that clears enable also drops a tick due on that same edge
  assign next_detectEnable = (regWrite && regAddr == ADDR_CFG_ONE) ?
    regWdata[POS_DETECT_ENABLE] : headsetDetectEnable;
  // reserved period code runs as the longest period
  assign periodSel = (detectionClockPeriod > PERIOD_CODE_MAX) ? PERIOD_CODE_MAX
    : detectionClockPeriod;
  assign periodLast = 2'((3'h1 << periodSel) - 3'h1);

  always_ff @(posedge sys_clk) begin
    if (reset || !headsetDetectEnable) begin
      baseCount <= '0;
      periodCount <= 2'h0;
      detectTick <= 1'b0;
    end else begin
      detectTick <= 1'b0;
      if (baseCount == ($bits(baseCount))'(DET_TICK_CYCLES - 1)) begin
        baseCount <= '0;
        if (periodCount >= periodLast) begin
          periodCount <= 2'h0;
          detectTick <= next_detectEnable;
        end else begin
          periodCount <= 2'(periodCount + 2'h1);
        end
      end else begin
        baseCount <= ($bits(baseCount))'(baseCount + 1'b1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // insertion time expressed in detection samples at the current period
  function automatic logic [CNT_W-1:0] insert_samples(input logic [2:0] code,
      input logic [1:0] period);
    logic [CNT_W-1:0] ms;
    ms = '0;
    if (code > INSERT_CODE_MAX) begin
      ms = CNT_NONE; // seven, and reserved six, give no debounce
    end else begin
      ms = CNT_W'(INSERT_BASE_MS << code);
    end
    return CNT_W'(ms >> period);
  endfunction

  logic [2:0] insertCode;
  logic [1:0] hookCode;

  assign insertCode = debCfg[POS_INSERT_LO +: 3];
  assign hookCode = debCfg[POS_HOOK_LO +: 2];

  hjd_deb_if jackIf();
  hjd_deb_if micIf();
  hjd_deb_if hookIf();

  assign jackIf.tick = detectTick;
  assign jackIf.enable = headsetDetectEnable;
  assign jackIf.raw = senseStable[0];
  assign jackIf.riseCount = insert_samples(insertCode, periodSel);
  assign jackIf.fallCount = debCfg[POS_REMOVAL] ? CNT_REMOVAL_FAST
    : CNT_REMOVAL_SLOW;

  assign micIf.tick = detectTick;
  assign micIf.enable = headsetDetectEnable && jackIf.state;
  assign micIf.raw = senseStable[1];
  assign micIf.riseCount = debCfg[POS_HP_DEBOUNCE] ? CNT_HP : CNT_NONE;
  assign micIf.fallCount = micIf.riseCount;

  assign hookIf.tick = detectTick;
  assign hookIf.enable = headsetDetectEnable && jackIf.state;
  assign hookIf.raw = senseStable[2];
  assign hookIf.riseCount = (hookCode == 2'h3) ? CNT_HOOK_THREE
    : (hookCode == 2'h2) ? CNT_HOOK_TWO : CNT_NONE;
  assign hookIf.fallCount = hookIf.riseCount;

  hjd_debounce jackDeb (.sys_clk(sys_clk), .reset(reset), .deb(jackIf.filt));
  hjd_debounce micDeb (.sys_clk(sys_clk), .reset(reset), .deb(micIf.filt));
  hjd_debounce hookDeb (.sys_clk(sys_clk), .reset(reset), .deb(hookIf.filt));

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      jackTypeFlag <= JACK_NONE;
      hookPressed <= 1'b0;
      couplingDc <= 1'b0;
      doubleSenseCurrent <= 1'b0;
      hookMaxOhm <= OHM_HOOK_LOW_AC;
      micMinOhm <= OHM_MIC_LOW;
      hookedMinOhm <= OHM_HOOKED_150;
      hookedMinValid <= 1'b0;
    end else begin
      jackTypeFlag <= !jackIf.state ? JACK_NONE
        : (micIf.state ? JACK_WITH_MIC : JACK_NO_MIC);
      hookPressed <= hookIf.state;
      couplingDc <= cfgOne[POS_COUPLING];
      doubleSenseCurrent <= cfgOne[POS_DOUBLE_CURRENT];
      if (cfgOne[POS_HOOK_THRESHOLD]) begin
        hookMaxOhm <= OHM_HOOK_HIGH;
        micMinOhm <= cfgOne[POS_COUPLING] ? OHM_MIC_HIGH_DC : OHM_MIC_HIGH_AC;
      end else begin
        hookMaxOhm <= cfgOne[POS_COUPLING] ? OHM_HOOK_LOW_DC : OHM_HOOK_LOW_AC;
        micMinOhm <= OHM_MIC_LOW;
      end
      case (cfgOne[POS_HOOKED_MIN_LO +: 2])
        2'h1: hookedMinOhm <= OHM_HOOKED_100;
        2'h2: hookedMinOhm <= OHM_HOOKED_50;
        default: hookedMinOhm <= OHM_HOOKED_150;
      endcase
      hookedMinValid <= !externalResistorType;
    end
  end
endmodule

// [testbench/hjd_plug.sv]
/*
  Plug in the jack: contact chatter after each plug change.
  Assumes sense lines are read through synchronisers.
*/
`timescale 1ns/1ns
module hjd_plug (
  input wire logic sys_clk,
  input wire logic plugged,
  input wire logic hasMic,
  input wire logic hookDown,
  output logic jackSense,
  output logic micSense,
  output logic hookSense
);
  logic last = 1'b0;
  logic flip = 1'b0;
  int bounce = 0;
  always @(posedge sys_clk) begin
    flip <= ~flip;
    last <= plugged;
    bounce <= (plugged != last) ? 9 : (bounce > 0) ? bounce - 1 : 0;
  end
  // chatter spans about two samples but toggles each clock, so stages two and three never agree and it never restarts a debounce run
  assign jackSense = (bounce > 0) ? flip : plugged;
  // an empty jack leaves the microphone line open, read as high impedance
  assign micSense = plugged ? hasMic : 1'b1;
  assign hookSense = plugged & hookDown;
endmodule

// [testbench/hjd_top_monitor.sv]
/*
  Port checks for hjd_top.
  Assumes hjd_pkg is compiled first; bound into every hjd_top.
*/
`timescale 1ns/1ns
module hjd_top_monitor
  import hjd_pkg::*;
#(
  parameter int DET_TICK_CYCLES = DET_BASE_CYCLES
)(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic externalResistorType,
  input wire logic headsetDetectEnable,
  input wire logic [11:0] hookMaxOhm,
  input wire logic [11:0] micMinOhm,
  input wire logic hookedMinValid,
  input wire logic detectTick,
  input wire logic [1:0] jackTypeFlag,
  input wire logic hookPressed
);
  int gap;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // time spent disabled is not counted, so the first tick after a restart is measured from the enable
  always_ff @(posedge sys_clk) begin
    if (reset || detectTick || !headsetDetectEnable) begin
      gap <= 0;
    end else begin
      gap <= gap + 1;
    end
  end
  sequence statusRead;
    regRead && regAddr == ADDR_STATUS ##1 $stable(jackTypeFlag);
  endsequence
  a_tick_enabled: assert property (detectTick |-> headsetDetectEnable)
    else $error("tick while disabled");
  a_tick_spacing: assert property (detectTick |-> gap >= DET_TICK_CYCLES - 2)
    else $error("ticks too close");
  a_off_clears: assert property (!headsetDetectEnable [*3] |->
    !jackTypeFlag && !hookPressed) else $error("state kept while disabled");
  a_flag_legal: assert property (jackTypeFlag != 2'h2)
    else $error("reserved jack flag");
  a_low_pair: assert property (micMinOhm == OHM_MIC_LOW |-> hookMaxOhm != OHM_HOOK_HIGH)
    else $error("low threshold pair wrong");
  a_high_pair: assert property (micMinOhm != OHM_MIC_LOW |-> hookMaxOhm == OHM_HOOK_HIGH)
    else $error("high threshold pair wrong");
  a_hooked_valid: assert property ($stable(externalResistorType) [*2] |->
    hookedMinValid == !externalResistorType) else $error("hooked valid wrong");
  a_status_read: assert property (statusRead |-> regRdata == {jackTypeFlag, 6'h00})
    else $error("status readback wrong");
endmodule
bind hjd_top hjd_top_monitor #(.DET_TICK_CYCLES(DET_TICK_CYCLES)) i_hjd_top_monitor (.sys_clk,
  .reset, .regAddr, .regRead, .regRdata, .externalResistorType, .headsetDetectEnable,
  .hookMaxOhm, .micMinOhm, .hookedMinValid, .detectTick, .jackTypeFlag, .hookPressed);

// [testbench/tb_hjd_top.sv]
/*
  Self-checking bench for hjd_top driving the plug model.
  Assumes the sample period is shortened to four clocks.
*/
`timescale 1ns/1ns
module tb_hjd_top
  import hjd_pkg::*;
;
  logic sys_clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
  logic [1:0] detectionClockPeriod = 2'h0, jackTypeFlag;
  logic externalResistorType = 1'b0, plugged = 1'b0, hasMic = 1'b0, hookDown = 1'b0;
  logic [11:0] hookMaxOhm, micMinOhm, hookedMinOhm;
  logic jackSense, micSense, hookSense, headsetDetectEnable, couplingDc;
  logic doubleSenseCurrent, hookedMinValid, detectTick, hookPressed;
  int mismatches = 0, comparisons = 0, cyc = 0;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  hjd_top #(.DET_TICK_CYCLES(4)) i_hjd_top (.sys_clk, .reset, .regAddr, .regWrite, .regWdata,
    .regRead, .regRdata, .detectionClockPeriod, .externalResistorType, .jackSense, .micSense,
    .hookSense, .headsetDetectEnable, .couplingDc, .doubleSenseCurrent, .hookMaxOhm,
    .micMinOhm, .hookedMinOhm, .hookedMinValid, .detectTick, .jackTypeFlag, .hookPressed);
  hjd_plug i_hjd_plug (.sys_clk, .plugged, .hasMic, .hookDown, .jackSense, .micSense,
    .hookSense);
  ////////////////////////////////////////
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic waitTicks(input int n);
    repeat (n) @(posedge sys_clk iff detectTick === 1'b1);
    #2;
  endtask
  // one access per call; an idle edge between calls keeps strobes single-cycle
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
    step(1);
    regAddr = a;
    regWdata = d;
    regWrite = w;
    regRead = !w;
    step(1);
    regWrite = 1'b0;
    regRead = 1'b0;
    if (!w) chk({4'h0, regRdata}, {4'h0, d});
  endtask
  task automatic after(input int n, input logic [1:0] f, input logic h);
    waitTicks(n);
    chk(12'(jackTypeFlag), 12'(f));
    chk(12'(hookPressed), 12'(h));
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    acc(ADDR_CFG_ONE, RESET_CFG_ONE, 1'b0);
    acc(ADDR_DEB_CFG, RESET_DEB_CFG, 1'b0);
    // reserved bits and reserved codes are written only as zero
    acc(ADDR_CFG_ONE, 8'h6e, 1'b1);
    chk(12'(headsetDetectEnable), 12'h001);
    acc(ADDR_CFG_ONE, 8'h6e, 1'b0);
    acc(ADDR_DEB_CFG, 8'h7f, 1'b1);
    acc(ADDR_DEB_CFG, 8'h7f, 1'b0);
    acc(ADDR_STATUS, 8'hf0, 1'b1);
    acc(ADDR_STATUS, 8'h00, 1'b0);
    acc(8'h30, 8'h00, 1'b0);
  endtask
  task automatic t_thresholds();
    logic [1:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 2'(i % 3);
      externalResistorType = i[0];
      acc(ADDR_CFG_ONE, {1'b0, i[0], c, i[1], i[2], 2'b10}, 1'b1);
      step(2);
      chk(hookMaxOhm, i[0] ? OHM_HOOK_HIGH : i[1] ? OHM_HOOK_LOW_DC : OHM_HOOK_LOW_AC);
      chk(micMinOhm, !i[0] ? OHM_MIC_LOW : i[1] ? OHM_MIC_HIGH_DC : OHM_MIC_HIGH_AC);
      chk(hookedMinOhm, c[1] ? OHM_HOOKED_50 : c[0] ? OHM_HOOKED_100 : OHM_HOOKED_150);
      chk(12'(hookedMinValid), 12'(!i[0]));
      chk(12'(couplingDc), 12'(i[1]));
      chk(12'(doubleSenseCurrent), 12'(i[2]));
    end
  endtask
  task automatic t_period();
    int start;
    for (int s = 0; s < 3; s++) begin
      detectionClockPeriod = 2'(s);
      waitTicks(2);
      start = cyc;
      waitTicks(1);
      chk(12'(cyc - start), 12'(4 << s));
    end
    detectionClockPeriod = 2'h0;
  endtask
  task automatic t_detect();
    acc(ADDR_DEB_CFG, 8'h43, 1'b1);
    plugged = 1'b1;
    after(12, JACK_NONE, 1'b0);
    after(10, JACK_NO_MIC, 1'b0);
    hasMic = 1'b1;
    after(1, JACK_NO_MIC, 1'b0);
    after(6, JACK_WITH_MIC, 1'b0);
    hookDown = 1'b1;
    after(1, JACK_WITH_MIC, 1'b0);
    after(6, JACK_WITH_MIC, 1'b1);
    acc(ADDR_STATUS, {JACK_WITH_MIC, 6'h00}, 1'b0);
    hookDown = 1'b0;
    after(6, JACK_WITH_MIC, 1'b0);
    plugged = 1'b0;
    after(3, JACK_WITH_MIC, 1'b0);
    after(7, JACK_NONE, 1'b0);
  endtask
  task automatic t_fast();
    acc(ADDR_CFG_ONE, 8'h00, 1'b1);
    chk(12'(headsetDetectEnable), 12'h000);
    plugged = 1'b1;
    hookDown = 1'b1;
    step(100);
    chk(12'(jackTypeFlag), 12'(JACK_NONE));
    chk(12'(hookPressed), 12'h000);
    acc(ADDR_DEB_CFG, 8'h3c, 1'b1);
    acc(ADDR_CFG_ONE, 8'h02, 1'b1);
    after(3, JACK_WITH_MIC, 1'b1);
    hookDown = 1'b0;
    // release changes state on the second tick; the flag follows a clock later
    after(3, JACK_WITH_MIC, 1'b0);
    plugged = 1'b0;
    after(2, JACK_WITH_MIC, 1'b0);
    after(6, JACK_NONE, 1'b0);
  endtask
  // insertion code one at the 4 ms period is eight samples; hook code two
  task automatic t_coded();
    detectionClockPeriod = 2'h2;
    acc(ADDR_DEB_CFG, 8'h0e, 1'b1);
    plugged = 1'b1;
    after(7, JACK_NONE, 1'b0);
    after(4, JACK_WITH_MIC, 1'b0);
    hookDown = 1'b1;
    after(2, JACK_WITH_MIC, 1'b0);
    after(1, JACK_WITH_MIC, 1'b1);
    hookDown = 1'b0;
    plugged = 1'b0;
    after(6, JACK_NONE, 1'b0);
    detectionClockPeriod = 2'h0;
  endtask
  initial begin
    step(16);
    reset = 1'b0;
    t_regs();
    t_thresholds();
    t_period();
    t_detect();
    t_fast();
    t_coded();
    stop_test();
  end
  initial begin
    #(50 * 20000);
    mismatches++;
    stop_test();
  end
endmodule
